// File: design/sop_port.sv
// Serial result-output port with parallel pin sharing and register access.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - Parallel modes drive the shared pins as result bits 4 and 5.
// - Serial mode turns the shared pins into clock divider select inputs.
// - Divider select slows the clock only in master read-after-convert.
// - Other serial setups leave the divider select pins undriven.
// - Clock source low: master, drives own serial clock out.
// - Clock source high: host clock gated by chip select shifts data.
// - Frame sync is active high when polarity input low, else low.
// - Serial clock invert input inverts the serial clock in every setup.
// - Read-during-convert sends previous result during conversion, other period.
// - Read-after-convert sends the current result once conversion ends.
// - Slave daisy input appears on output 18 clock periods after start.
// - Slave output updates on rising clock, swapped when inverted.
// - Master frame sync is active from read start while output data valid; slave mode holds it low.
// - Slave read unfinished at conversion end is dropped, error pulses.
// - Results leave the shift register most significant bit first.
module sop_port (
    input wire logic mclk_in,                          // 50 MHz clock.
    input wire logic rst_n_in,                         // Async reset, active low.
    input wire logic [1:0] mode_in,                    // Interface mode pins.
    input wire logic conv_start_in,                    // Conversion start pulse.
    input wire logic conv_done_in,                     // Conversion done pulse.
    input wire logic [sop_pkg::RES_W-1:0] result_in,   // Finished result.
    input wire logic [1:0] div_pin_in,                 // Shared pins, input side.
    output logic [1:0] div_pin_out,                    // Shared pins, output side.
    output logic div_pin_oe_out,                       // Shared pins drive enable.
    input wire logic clock_source_select_in,           // High selects slave.
    input wire logic frame_sync_polarity_select_in,    // High: sync active low.
    input wire logic serial_clock_invert_in,           // Inverts serial clock.
    input wire logic read_during_convert_select_in,    // Master read mode.
    input wire logic daisy_chain_input_in,             // Daisy-chain data in.
    input wire logic cs_n_in,                          // Chip select, active low.
    input wire logic sclk_in,                          // Serial clock pin, input.
    output logic sclk_out,                             // Serial clock pin, output.
    output logic sclk_oe_out,                          // Serial clock drive enable.
    output logic serial_result_output_out,             // Serial data out.
    output logic frame_sync_out,                       // Frame sync out.
    output logic incomplete_read_flag_out,             // Incomplete read pulse.
    input wire logic [sop_pkg::ADDR_W-1:0] addr_in,    // Register address.
    input wire logic [31:0] wdata_in,                  // Write data.
    input wire logic wr_in,                            // Write strobe.
    input wire logic rd_in,                            // Read strobe.
    output logic [31:0] rdata_out,                     // Read data, next cycle.
    output logic irq_out                               // Interrupt, level.
);
    typedef struct packed {
        logic [sop_pkg::PIN_W-1:0] s1;
        logic [sop_pkg::PIN_W-1:0] s2;
        logic sclk_d;
        logic cs_d;
        sop_pkg::sop_state_t st;
        logic [4:0] cnt;
        logic [sop_pkg::RES_W-1:0] sh;
        logic [sop_pkg::RES_W-1:0] prev_res;
        logic isclk;
        logic serial_result_output;
        logic sclk_o;
        logic sclk_oe;
        logic fsync;
        logic rderr;
        logic [1:0] par_o;
        logic par_oe;
        logic [1:0] sts;
        logic [1:0] msk;
        logic [sop_pkg::DIV_W-1:0] div;
        logic [31:0] rdata;
        logic irq;
    } sop_port_st_t;

    sop_port_st_t q, d;

    logic [1:0] mode_s;
    logic ext_s;
    logic frame_sync_polarity_select_s;
    logic serial_clock_invert_s;
    logic rdc_s;
    logic daisy_chain_input_s;
    logic [1:0] dsel_s;
    logic sclk_s;
    logic cs_s;
    logic serial;
    logic master;
    logic slave;
    logic eff_rise;
    logic cs_fall;
    logic tick;
    logic [sop_pkg::PER_W-1:0] period;
    logic [1:0] ev;

    // Only the second synchroniser stage is decoded.
    assign {mode_s, ext_s, frame_sync_polarity_select_s, serial_clock_invert_s, rdc_s, daisy_chain_input_s, dsel_s, sclk_s, cs_s} = q.s2;
    assign serial = (mode_s == sop_pkg::MODE_SERIAL);
    assign master = serial && !ext_s;
    assign slave = serial && ext_s;
    assign cs_fall = q.cs_d && !cs_s;
    // Host clock, corrected for inversion, so data moves on its rising edge.
    assign eff_rise = (sclk_s ^ serial_clock_invert_s) && !(q.sclk_d ^ serial_clock_invert_s);

    always_comb begin
        period = {{(sop_pkg::PER_W - sop_pkg::DIV_W){1'b0}}, q.div};
        if (!rdc_s) begin
            period = period << dsel_s;
        end
    end

    sop_tick_gen #(
        .W(sop_pkg::PER_W)
    ) u_tick (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .run_in(master && q.st == sop_pkg::SOP_MSHIFT),
        .period_in(period),
        .tick_out(tick)
    );

    always_comb begin
        d = q;
        ev = 2'h0;
        d.s1 = {mode_in, clock_source_select_in, frame_sync_polarity_select_in,
                serial_clock_invert_in, read_during_convert_select_in,
                daisy_chain_input_in, div_pin_in, sclk_in, cs_n_in};
        d.s2 = q.s1;
        d.sclk_d = sclk_s;
        d.cs_d = cs_s;
        d.rderr = 1'b0;
        d.par_oe = !serial;
        d.par_o = result_in[5:4];
        if (conv_done_in) begin
            d.prev_res = result_in;
        end
        case (q.st)
            sop_pkg::SOP_IDLE: begin
                d.isclk = 1'b0;
                if (master && !rdc_s && conv_done_in) begin
                    d.sh = result_in;
                    d.serial_result_output = result_in[sop_pkg::RES_W-1];
                    d.cnt = 5'h0;
                    d.st = sop_pkg::SOP_MSHIFT;
                end else if (master && rdc_s && conv_start_in) begin
                    d.sh = q.prev_res;
                    d.serial_result_output = q.prev_res[sop_pkg::RES_W-1];
                    d.cnt = 5'h0;
                    d.st = sop_pkg::SOP_MSHIFT;
                end else if (slave && cs_fall) begin
                    d.sh = q.prev_res;
                    d.serial_result_output = q.prev_res[sop_pkg::RES_W-1];
                    d.cnt = 5'h0;
                    d.st = sop_pkg::SOP_SSHIFT;
                end
            end
            sop_pkg::SOP_MSHIFT: begin
                if (!master) begin
                    d.st = sop_pkg::SOP_IDLE;
                end else if (tick) begin
                    d.isclk = !q.isclk;
                    // Data moves on the falling internal edge, stable at the rising edge.
                    if (q.isclk) begin
                        if (q.cnt == sop_pkg::LAST_BIT) begin
                            d.st = sop_pkg::SOP_IDLE;
                            ev[sop_pkg::STS_FRAME] = 1'b1;
                        end else begin
                            d.cnt = q.cnt + 5'h1;
                            d.sh = {q.sh[sop_pkg::RES_W-2:0], 1'b0};
                            d.serial_result_output = q.sh[sop_pkg::RES_W-2];
                        end
                    end
                end
            end
            sop_pkg::SOP_SSHIFT: begin
                if (conv_done_in && q.cnt < sop_pkg::DAISY_DELAY) begin
                    d.rderr = 1'b1;
                    ev[sop_pkg::STS_RDERR] = 1'b1;
                    d.st = sop_pkg::SOP_IDLE;
                end else if (!slave || cs_s) begin
                    d.st = sop_pkg::SOP_IDLE;
                end else if (eff_rise) begin
                    d.sh = {q.sh[sop_pkg::RES_W-2:0], daisy_chain_input_s};
                    d.serial_result_output = q.sh[sop_pkg::RES_W-2];
                    if (q.cnt != 5'h1F) begin
                        d.cnt = q.cnt + 5'h1;
                    end
                    if (q.cnt + 5'h1 == sop_pkg::DAISY_DELAY) begin
                        ev[sop_pkg::STS_FRAME] = 1'b1;
                    end
                end
            end
            default: begin
                d.st = sop_pkg::SOP_IDLE;
            end
        endcase
        d.sclk_oe = master;
        d.sclk_o = master && (d.isclk ^ serial_clock_invert_s);
        d.fsync = master && ((d.st == sop_pkg::SOP_MSHIFT) ^ frame_sync_polarity_select_s);
        d.rdata = 32'h0;
        if (rd_in) begin
            case (addr_in)
                sop_pkg::OFS_STATUS: d.rdata = {30'h0, q.sts};
                sop_pkg::OFS_MASK: d.rdata = {30'h0, q.msk};
                sop_pkg::OFS_CLKDIV: d.rdata = {24'h0, q.div};
                sop_pkg::OFS_STATE: d.rdata = {25'h0, q.cnt, q.st};
                default: d.rdata = 32'h0;
            endcase
        end
        // A new event wins over a write-one clear in the same cycle.
        d.sts = q.sts;
        if (wr_in && addr_in == sop_pkg::OFS_STATUS) begin
            d.sts = q.sts & ~wdata_in[1:0];
        end
        d.sts = d.sts | ev;
        if (wr_in && addr_in == sop_pkg::OFS_MASK) begin
            d.msk = wdata_in[1:0];
        end
        if (wr_in && addr_in == sop_pkg::OFS_CLKDIV && wdata_in[7:0] != 8'h0) begin
            d.div = wdata_in[7:0];
        end
        d.irq = |(d.sts & d.msk);
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.s1 <= sop_pkg::SYNC_RST;
            q.s2 <= sop_pkg::SYNC_RST;
            q.cs_d <= 1'b1;
            q.st <= sop_pkg::SOP_IDLE;
            q.sts <= sop_pkg::STATUS_RST;
            q.msk <= sop_pkg::MASK_RST;
            q.div <= sop_pkg::CLKDIV_RST;
        end else begin
            q <= d;
        end
    end

    assign div_pin_out = q.par_o;
    assign div_pin_oe_out = q.par_oe;
    assign sclk_out = q.sclk_o;
    assign sclk_oe_out = q.sclk_oe;
    assign serial_result_output_out = q.serial_result_output;
    assign frame_sync_out = q.fsync;
    assign incomplete_read_flag_out = q.rderr;
    assign rdata_out = q.rdata;
    assign irq_out = q.irq;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_err_pulse;
        incomplete_read_flag_out ##1 !incomplete_read_flag_out;
    endsequence

    property p_par_pins;
        !serial |=> div_pin_oe_out && div_pin_out == $past(result_in[5:4]);
    endproperty
    a_par_pins: assert property (p_par_pins) else $error("shared pins not driven");

    property p_div_hiz;
        serial |=> !div_pin_oe_out;
    endproperty
    a_div_hiz: assert property (p_div_hiz) else $error("divider pins driven");

    property p_master_clk;
        master |=> sclk_oe_out;
    endproperty
    a_master_clk: assert property (p_master_clk) else $error("master clock off");

    property p_sync_level;
        q.st == sop_pkg::SOP_MSHIFT && $past(master) |-> frame_sync_out != $past(frame_sync_polarity_select_s);
    endproperty
    a_sync_level: assert property (p_sync_level) else $error("frame sync level");

    property p_clk_inv;
        $past(master) |-> sclk_out == (q.isclk ^ $past(serial_clock_invert_s));
    endproperty
    a_clk_inv: assert property (p_clk_inv) else $error("serial clock polarity");

    property p_rderr;
        q.st == sop_pkg::SOP_SSHIFT && conv_done_in && q.cnt < sop_pkg::DAISY_DELAY
            |=> s_err_pulse;
    endproperty
    a_rderr: assert property (p_rderr) else $error("missing read error pulse");

    property p_rac_msb;
        q.st == sop_pkg::SOP_IDLE && master && !rdc_s && conv_done_in
            |=> serial_result_output_out == $past(result_in[17]);
    endproperty
    a_rac_msb: assert property (p_rac_msb) else $error("first bit not MSB");

    property p_rdc_start;
        q.st == sop_pkg::SOP_IDLE && master && rdc_s && conv_start_in
            |=> q.st == sop_pkg::SOP_MSHIFT ##0 q.sh == $past(q.prev_res);
    endproperty
    a_rdc_start: assert property (p_rdc_start) else $error("no read during convert");

    property p_slave_shift;
        q.st == sop_pkg::SOP_SSHIFT && slave && !cs_s && eff_rise && !conv_done_in
            |=> serial_result_output_out == $past(q.sh[16]);
    endproperty
    a_slave_shift: assert property (p_slave_shift) else $error("slave shift");

    property p_rac_load;
        q.st == sop_pkg::SOP_IDLE && master && !rdc_s && conv_done_in
            |=> q.st == sop_pkg::SOP_MSHIFT ##0 q.sh == $past(result_in);
    endproperty
    a_rac_load: assert property (p_rac_load) else $error("current result not loaded");

    sequence s_slave_armed;
        q.st == sop_pkg::SOP_IDLE && slave && cs_fall;
    endsequence

    property p_slave_load;
        s_slave_armed
            |=> q.st == sop_pkg::SOP_SSHIFT
                ##0 serial_result_output_out == $past(q.prev_res[17]);
    endproperty
    a_slave_load: assert property (p_slave_load) else $error("slave read not started");

    property p_daisy_in;
        q.st == sop_pkg::SOP_SSHIFT && slave && !cs_s && eff_rise && !conv_done_in
            |=> q.sh[0] == $past(daisy_chain_input_s);
    endproperty
    a_daisy_in: assert property (p_daisy_in) else $error("daisy bit not taken");

    property p_sync_idle;
        q.st != sop_pkg::SOP_MSHIFT && $past(master)
            |-> frame_sync_out == $past(frame_sync_polarity_select_s);
    endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("frame sync active outside");

    property p_sclk_off;
        !master |=> !sclk_oe_out && !sclk_out;
    endproperty
    a_sclk_off: assert property (p_sclk_off) else $error("serial clock driven");

    property p_frame_done;
        q.st == sop_pkg::SOP_MSHIFT && master && tick && q.isclk
            && q.cnt == sop_pkg::LAST_BIT
            |=> q.st == sop_pkg::SOP_IDLE ##0 q.sts[sop_pkg::STS_FRAME];
    endproperty
    a_frame_done: assert property (p_frame_done) else $error("frame end missing");

    property p_slave_drop;
        q.st == sop_pkg::SOP_SSHIFT && conv_done_in && q.cnt < sop_pkg::DAISY_DELAY
            |=> q.st == sop_pkg::SOP_IDLE ##0 q.sts[sop_pkg::STS_RDERR];
    endproperty
    a_slave_drop: assert property (p_slave_drop) else $error("unfinished read kept");
endmodule

// File: design/sop_pkg.sv
// Constants and types shared by the serial result-output port.
package sop_pkg;
    localparam int RES_W = 18;
    localparam int ADDR_W = 4;
    localparam int DIV_W = 8;
    localparam int PER_W = 12;
    localparam int PIN_W = 11;
    localparam logic [1:0] MODE_SERIAL = 2'h3;
    localparam logic [4:0] LAST_BIT = 5'h11;
    localparam logic [4:0] DAISY_DELAY = 5'h12;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_MASK = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_CLKDIV = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_STATE = 4'h3;
    localparam int STS_FRAME = 0;
    localparam int STS_RDERR = 1;
    localparam logic [1:0] STATUS_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [DIV_W-1:0] CLKDIV_RST = 8'h02;
    // Synchroniser reset: parallel mode, chip select high, serial clock at its idle low.
    localparam logic [PIN_W-1:0] SYNC_RST = 11'h001;
    typedef enum logic [1:0] {SOP_IDLE, SOP_MSHIFT, SOP_SSHIFT} sop_state_t;
endpackage

// File: design/sop_tick_gen.sv
// Enable-pulse divider that makes the master serial clock rate.
`timescale 1ns/1ps
module sop_tick_gen #(
    parameter int W = 12
) (
    input wire logic mclk_in,          // System clock.
    input wire logic rst_n_in,         // Asynchronous reset, active low.
    input wire logic run_in,           // Counts while high, restarts while low.
    input wire logic [W-1:0] period_in, // Cycles between pulses.
    output logic tick_out              // One-cycle enable pulse.
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } sop_tick_st_t;

    sop_tick_st_t q, d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (!run_in) begin
            d.cnt = '0;
        end else if (q.cnt + W'(1) >= period_in) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + W'(1);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_out = q.tick;
endmodule

// File: verification/sop_host.sv
// Host-side model: slave clock source and master frame receiver.
`timescale 1ns/1ps
module sop_host (
    input wire logic mclk_in,  // System clock.
    input wire logic sclk_in,  // Device serial clock.
    input wire logic sdo_in,   // Device serial data.
    input wire logic sync_in,  // Device frame sync.
    output logic cs_n_out,     // Chip select to device, active low.
    output logic sclk_out      // Serial clock to device.
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
    end
    // Phases of four cycles keep the clock slow enough for the device.
    task automatic slave_read(input int n, input logic inv, input logic hold,
                              output logic [31:0] w);
        w = '0;
        @(posedge mclk_in);
        sclk_out <= inv;
        cs_n_out <= 1'b0;
        repeat (6) @(posedge mclk_in);
        for (int i = 0; i < n; i++) begin
            w = {w[30:0], sdo_in};
            sclk_out <= ~inv;
            repeat (4) @(posedge mclk_in);
            sclk_out <= inv;
            repeat (4) @(posedge mclk_in);
        end
        if (!hold) begin
            cs_n_out <= 1'b1;
        end
    endtask
    task automatic release_cs();
        @(posedge mclk_in);
        cs_n_out <= 1'b1;
    endtask
    // Takes one bit at each active clock edge and times the clock period.
    task automatic master_read(input logic inv, input logic pol, output logic [31:0] w,
                               output int per, output logic ok);
        logic prev;
        int cnt;
        int t;
        int last;
        w = '0;
        per = 0;
        ok = 1'b1;
        cnt = 0;
        t = 0;
        last = 0;
        prev = 1'b0;
        while (cnt < 18 && t < 2000) begin
            @(posedge mclk_in);
            #1;
            t++;
            if ((sclk_in ^ inv) === 1'b1 && !prev) begin
                w = {w[30:0], sdo_in};
                if (sync_in !== ~pol) begin
                    ok = 1'b0;
                end
                if (cnt > 0) begin
                    per = t - last;
                end
                last = t;
                cnt++;
            end
            prev = sclk_in ^ inv;
        end
    endtask
endmodule

// File: verification/sop_port_tb.sv
// Self-checking bench for the serial result-output port.
`timescale 1ns/1ps
module sop_port_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] cf = 8'h00;
    logic start = 1'b0;
    logic done = 1'b0;
    logic daisy = 1'b0;
    logic [sop_pkg::RES_W-1:0] result = '0;
    logic [sop_pkg::ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] dpo;
    logic [1:0] dpin;
    logic dpoe, cs_n, sclk_h, sclk_d, sclk_oe, sdo, fsync, rderr, irq;
    logic [31:0] rdata;
    logic [31:0] w;
    logic ok;
    int per;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    always #10 mclk = ~mclk;
    assign dpin = dpoe ? dpo : cf[1:0];
    sop_port u_dut (
        .mclk_in(mclk), .rst_n_in(rst_n), .mode_in(cf[7:6]),
        .conv_start_in(start), .conv_done_in(done), .result_in(result),
        .div_pin_in(dpin), .div_pin_out(dpo), .div_pin_oe_out(dpoe),
        .clock_source_select_in(cf[5]), .frame_sync_polarity_select_in(cf[4]),
        .serial_clock_invert_in(cf[3]), .read_during_convert_select_in(cf[2]),
        .daisy_chain_input_in(daisy), .cs_n_in(cs_n), .sclk_in(sclk_h),
        .sclk_out(sclk_d), .sclk_oe_out(sclk_oe), .serial_result_output_out(sdo),
        .frame_sync_out(fsync), .incomplete_read_flag_out(rderr), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq)
    );
    sop_host u_host (
        .mclk_in(mclk), .sclk_in(sclk_d), .sdo_in(sdo), .sync_in(fsync),
        .cs_n_out(cs_n), .sclk_out(sclk_h)
    );
    task automatic test_done();
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic reg_wr(input logic [sop_pkg::ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic reg_chk(input string what, input logic [sop_pkg::ADDR_W-1:0] a,
                           input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        cmp(what, exp, rdata);
    endtask
    task automatic cfg(input logic [7:0] v);
        @(posedge mclk);
        cf <= v;
        settle(6);
    endtask
    task automatic conv(input logic is_start, input logic [sop_pkg::RES_W-1:0] r);
        @(posedge mclk);
        result <= r;
        start <= is_start;
        done <= ~is_start;
        @(posedge mclk);
        start <= 1'b0;
        done <= 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        reg_chk("status", sop_pkg::OFS_STATUS, 32'h0);
        reg_chk("mask", sop_pkg::OFS_MASK, 32'h0);
        reg_chk("clkdiv", sop_pkg::OFS_CLKDIV, 32'h2);
        reg_chk("unmapped", 4'hF, 32'h0);
        conv(1'b0, 18'h00030);
        settle(3);
        cmp("div_pin_oe", 32'h1, dpoe);
        cmp("div_pin_out", 32'h3, dpo);
        cfg(8'hC0);
        cmp("sclk_oe", 32'h1, sclk_oe);
        cmp("div_pin_oe", 32'h0, dpoe);
        reg_wr(sop_pkg::OFS_MASK, 32'h1);
        conv(1'b0, 18'h2A5C3);
        u_host.master_read(1'b0, 1'b0, w, per, ok);
        cmp("master word", 32'h2A5C3, w);
        cmp("master period", 32'h4, per);
        cmp("sync active", 32'h1, ok);
        settle(40);
        cmp("irq", 32'h1, irq);
        reg_chk("status", sop_pkg::OFS_STATUS, 32'h1);
        reg_wr(sop_pkg::OFS_STATUS, 32'h1);
        reg_chk("status", sop_pkg::OFS_STATUS, 32'h0);
        cmp("irq", 32'h0, irq);
        reg_wr(sop_pkg::OFS_CLKDIV, 32'h3);
        reg_wr(sop_pkg::OFS_CLKDIV, 32'h0);
        reg_chk("clkdiv", sop_pkg::OFS_CLKDIV, 32'h3);
        cfg(8'hC2);
        conv(1'b0, 18'h1F00E);
        u_host.master_read(1'b0, 1'b0, w, per, ok);
        cmp("master word", 32'h1F00E, w);
        cmp("master period", 32'd24, per);
        cfg(8'hDE);
        cmp("div_pin_oe", 32'h0, dpoe);
        cmp("sclk idle", 32'h1, sclk_d);
        conv(1'b0, 18'h3C3A5);
        conv(1'b1, 18'h00001);
        u_host.master_read(1'b1, 1'b1, w, per, ok);
        cmp("previous word", 32'h3C3A5, w);
        cmp("rdc period", 32'h6, per);
        cmp("sync active low", 32'h1, ok);
        @(posedge mclk);
        daisy <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            cfg(8'hE0 | (8'(i) << 3));
            cmp("sclk_oe", 32'h0, sclk_oe);
            conv(1'b0, 18'h2B3C4);
            u_host.slave_read(20, i[0], 1'b0, w);
            cmp("slave word", 32'hACF13, w);
        end
        cfg(8'hE0);
        reg_wr(sop_pkg::OFS_STATUS, 32'h3);
        u_host.slave_read(5, 1'b0, 1'b1, w);
        conv(1'b0, 18'h00000);
        #1;
        for (int k = 0; k < 8 && rderr !== 1'b1; k++) settle(1);
        cmp("read flag", 32'h1, rderr);
        settle(1);
        cmp("read flag pulse", 32'h0, rderr);
        u_host.release_cs();
        reg_chk("state", sop_pkg::OFS_STATE, 32'h14);
        reg_chk("status", sop_pkg::OFS_STATUS, 32'h2);
        cmp("irq masked", 32'h0, irq);
        reg_wr(sop_pkg::OFS_MASK, 32'h2);
        settle(2);
        cmp("irq", 32'h1, irq);
        reg_wr(sop_pkg::OFS_STATUS, 32'h2);
        settle(2);
        cmp("irq cleared", 32'h0, irq);
        test_done();
    end
endmodule
